// ### hw/dbgca_top.sv
// Debug comparator A: compare registers, APB slave and match output.
`timescale 1ns/1ps
`default_nettype none
`include "dbgca_consts.svh"

module dbgca_top
  import dbgca_pkg::*;
(
  // Clock and resets.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   por_n,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`DBGCA_AW-1:0]   paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Debug control levels from the rest of the debug module.
  input  wire logic                   debug_module_enable,
  input  wire logic                   trig_begin_align,
  input  wire logic                   end_trace_reset,
  // Core address bus and the comparator result.
  input  wire dbgca_addr_t            core_addr,
  output logic                        cmp_a_match
);

  // Compare bytes, upper and lower.
  dbgca_byte_t  upper_q;
  dbgca_byte_t  lower_q;
  // Set while the next system reset must spare the compare bytes.
  logic         keep_q;
  // Two-stage synchroniser of the released system reset.
  logic         rst_s1_q;
  logic         rst_s2_q;
  // Read data captured in the setup cycle.
  logic [31:0]  rdata_q;
  // Reset that actually clears the compare bytes.
  wire          cmp_rst_n;
  // Decoded register selection.
  dbgca_sel_e   sel;
  // Address falls on a word boundary, in or out of the map.
  wire          aligned;
  wire [9:0]    word_idx;
  // Phase strobes of the APB transfer.
  wire          setup_ph;
  wire          access_ph;
  // Write strobes of the two compare bytes.
  wire          wr_upper;
  wire          wr_lower;
  // Preservation condition evaluated while running.
  wire          keep_d;
  // Status word and the read mux result.
  wire [31:0]   status_w;
  logic [31:0]  rdata_d;

  // The word index and the alignment of the byte address.
  assign word_idx = paddr[`DBGCA_AW-1:2];
  assign aligned  = (paddr[1:0] == 2'h0);

  // Decode the address into one of the three registers.
  always_comb
  begin
    sel = DBGCA_SEL_NONE;
    if (aligned)
    begin
      case (word_idx)
        `DBGCA_IDX_UPPER:  sel = DBGCA_SEL_UPPER;
        `DBGCA_IDX_LOWER:  sel = DBGCA_SEL_LOWER;
        `DBGCA_IDX_STATUS: sel = DBGCA_SEL_STATUS;
        default:           sel = DBGCA_SEL_NONE;
      endcase
    end
  end

  // Setup and access phases of an APB transfer.
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;

  // Writes land at the access edge and need byte lane zero.
  assign wr_upper = access_ph & pwrite & pstrb[0] &
                    (sel == DBGCA_SEL_UPPER);
  assign wr_lower = access_ph & pwrite & pstrb[0] &
                    (sel == DBGCA_SEL_LOWER);

  // The slave never inserts wait states.
  assign pready = access_ph;

  // An unmapped or misaligned address ends with an error.
  assign pslverr = access_ph & (sel == DBGCA_SEL_NONE);

  // Read data leave the register captured in the setup cycle.
  assign prdata = rdata_q;

  // Spare the bytes only when enabled and aligned to the end.
  assign keep_d = end_trace_reset & debug_module_enable &
                  ~trig_begin_align;

  // Power-on always clears; the system reset clears unless spared.
  assign cmp_rst_n = por_n & (presetn | keep_q);

  // Status shows the match, the keep flag and the enable level.
  assign status_w = {29'h0,
                     debug_module_enable,
                     keep_q,
                     cmp_a_match};

  // Select the word that a read returns.
  always_comb
  begin
    case (sel)
      DBGCA_SEL_UPPER:  rdata_d = {24'h0, upper_q};
      DBGCA_SEL_LOWER:  rdata_d = {24'h0, lower_q};
      DBGCA_SEL_STATUS: rdata_d = status_w;
      default:          rdata_d = 32'h0;
    endcase
  end

  // Capture read data in the setup cycle so it is stable in access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0;
    end
    else if (setup_ph)
    begin
      rdata_q <= pwrite ? 32'h0 : rdata_d;
    end
  end

  // Follow the release of the system reset on the local clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // The keep flag tracks its condition while running, freezes in system reset and clears at power-on.
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      keep_q <= 1'b0;
    end
    else if (rst_s2_q)
    begin
      keep_q <= keep_d;
    end
  end

  // Upper compare byte: expected levels of address bits 15..8.
  always_ff @(posedge pclk or negedge cmp_rst_n)
  begin
    if (!cmp_rst_n)
    begin
      upper_q <= `DBGCA_UPPER_RST;
    end
    else if (wr_upper)
    begin
      upper_q <= pwdata[7:0];
    end
  end

  // Lower compare byte: expected levels of address bits 7..0.
  always_ff @(posedge pclk or negedge cmp_rst_n)
  begin
    if (!cmp_rst_n)
    begin
      lower_q <= `DBGCA_LOWER_RST;
    end
    else if (wr_lower)
    begin
      lower_q <= pwdata[7:0];
    end
  end

  // Bitwise comparison of the core address with both bytes.
  dbgca_cmp u_cmp
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .expect_val ({upper_q, lower_q}),
    .core_addr  (core_addr),
    .match_q    (cmp_a_match)
  );

  // A full APB write to the lower byte, setup then access.
  sequence s_wr_lower;
    (psel && !penable && pwrite && pstrb[0] &&
     sel == DBGCA_SEL_LOWER)
    ##1 (psel && penable && pwrite);
  endsequence

  // A full APB write to the upper byte, setup then access.
  sequence s_wr_upper;
    (psel && !penable && pwrite && pstrb[0] &&
     sel == DBGCA_SEL_UPPER)
    ##1 (psel && penable && pwrite);
  endsequence

  // A whole address equal to both bytes gives a match next cycle.
  a_match_full: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_addr == {upper_q, lower_q}) |=> cmp_a_match)
    else $error("Equal address did not raise the match.");

  // Any upper address bit off its compare bit blocks the match.
  a_high_miss: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_addr[15:8] != upper_q) |=> !cmp_a_match)
    else $error("Match raised despite an upper byte difference.");

  // Any lower address bit off its compare bit blocks the match.
  a_low_miss: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_addr[7:0] != lower_q) |=> !cmp_a_match)
    else $error("Match raised despite a lower byte difference.");

  // A match means every address bit sat at its compare level.
  a_bit_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_a_match |->
      ($past(core_addr) ^ {$past(upper_q), $past(lower_q)}) == 16'h0)
    else $error("Match seen with a bit at the wrong level.");

  // A write to the upper byte stores lane zero at the access edge.
  a_write_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_upper |=> (upper_q == $past(pwdata[7:0])))
    else $error("Upper byte write was not stored.");

  // A write to the lower byte stores lane zero at the access edge.
  a_write_lower: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_lower |=> (lower_q == $past(pwdata[7:0])))
    else $error("Lower byte write was not stored.");

  // An unspared system reset holds both bytes at their reset values.
  a_reset_values: assert property (
    @(posedge pclk) disable iff (!por_n)
    (!presetn && !keep_q) |->
      (upper_q == `DBGCA_UPPER_RST && lower_q == `DBGCA_LOWER_RST))
    else $error("Reset values of the compare bytes are wrong.");

  // A spared system reset leaves both bytes unchanged.
  a_keep_through: assert property (
    @(posedge pclk) disable iff (!por_n)
    (!presetn && keep_q) ##1 !presetn |->
      ($stable(upper_q) && $stable(lower_q)))
    else $error("Compare bytes changed during an end-run reset.");

  // The keep flag drops when enable or end alignment is missing.
  a_keep_cond: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rst_s2_q && end_trace_reset &&
     (!debug_module_enable || trig_begin_align)) |=> !keep_q)
    else $error("Keep flag set without enable and end alignment.");

endmodule

`default_nettype wire

// ### inc/dbgca_consts.svh
// Constants of debug comparator A: offsets, reset values, field positions.
// Operation
// - Upper byte sets expected levels, address 15..8.
// - Compare bit zero expects low, one expects high.
// - Lower byte sets expected levels, address 7..0.
// - End-run reset, enabled, end-aligned: registers keep contents.
`ifndef DBGCA_CONSTS_SVH
`define DBGCA_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define DBGCA_IDX_UPPER   10'h000
`define DBGCA_IDX_LOWER   10'h001
`define DBGCA_IDX_STATUS  10'h002

// Width of the APB byte address.
`define DBGCA_AW          12

// Reset values of the two compare bytes.
`define DBGCA_UPPER_RST   8'hff
`define DBGCA_LOWER_RST   8'hfe

// Bit positions inside the status register.
`define DBGCA_ST_MATCH    0
`define DBGCA_ST_KEEP     1
`define DBGCA_ST_ENABLE   2

`endif

// ### inc/dbgca_pkg.sv
// Types shared by the comparator A design files.
package dbgca_pkg;

  // One compare byte as held in a register.
  typedef logic [7:0] dbgca_byte_t;

  // The full sixteen-bit address seen on the core bus.
  typedef logic [15:0] dbgca_addr_t;

  // Which register an APB address selects.
  typedef enum logic [1:0]
  {
    DBGCA_SEL_NONE,
    DBGCA_SEL_UPPER,
    DBGCA_SEL_LOWER,
    DBGCA_SEL_STATUS
  } dbgca_sel_e;

endpackage

// ### hw/dbgca_cmp.sv
// Bitwise address comparator with a registered match output.
`timescale 1ns/1ps
`default_nettype none

module dbgca_cmp
  import dbgca_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Expected value and the address under test.
  input  wire dbgca_addr_t expect_val,
  input  wire dbgca_addr_t core_addr,
  // Registered match result.
  output logic             match_q
);

  // One equality flag per address bit.
  logic [15:0] bit_eq;
  // All bits equal in this cycle.
  wire         match_d;

  // Each bit matches when the address level equals the compare bit.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_bit
      assign bit_eq[gi] = ~(core_addr[gi] ^ expect_val[gi]);
    end
  endgenerate

  // The match needs every one of the sixteen bits to agree.
  assign match_d = &bit_eq;

  // Register the result so the output leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_q <= 1'b0;
    end
    else
    begin
      match_q <= match_d;
    end
  end

endmodule

`default_nettype wire

// ### verif/dbgca_core_model.sv
// Core address bus model that presents one address per cycle.
`timescale 1ns/1ps
`default_nettype none

module dbgca_core_model
  import dbgca_pkg::*;
(
  // Bus clock.
  input  wire logic        pclk,
  // Address the core is to issue next.
  input  wire dbgca_addr_t next_addr,
  // Address bus seen by the comparator.
  output var  dbgca_addr_t core_addr
);
  // The core launches a new address on each rising edge, as a fetch does.
  always_ff @(posedge pclk)
  begin
    core_addr <= next_addr;
  end
endmodule

`default_nettype wire

// ### verif/tb_top.sv
// Testbench for comparator A: register access, match and reset kinds.
`timescale 1ns/1ps
`default_nettype none
`include "dbgca_consts.svh"

module tb_top
  import dbgca_pkg::*;
;
  localparam logic [11:0] A_UP = {`DBGCA_IDX_UPPER, 2'b00}; // Upper byte.
  localparam logic [11:0] A_LO = {`DBGCA_IDX_LOWER, 2'b00}; // Lower byte.
  localparam logic [11:0] A_ST = {`DBGCA_IDX_STATUS, 2'b00}; // Status word.
  logic        pclk    = 1'b0;   // Bus clock.
  logic        presetn = 1'b0;   // System reset.
  logic        por_n   = 1'b0;   // Power-on reset.
  logic        psel    = 1'b0;   // APB select.
  logic        penable = 1'b0;   // APB enable.
  logic        pwrite  = 1'b0;   // APB direction.
  logic [11:0] paddr   = 12'h000; // APB address.
  logic [31:0] pwdata  = 32'h0; // APB write data.
  logic [31:0] prdata;          // APB read data.
  logic        pready;          // APB ready.
  logic        pslverr;         // APB error.
  logic        mod_en  = 1'b0;  // Debug module enable level.
  logic        align   = 1'b0;  // Begin-aligned trigger select.
  logic        etr     = 1'b0;  // End-trace reset request.
  dbgca_addr_t req     = 16'h0; // Address the core issues next.
  dbgca_addr_t core_addr;       // Core address bus.
  logic        match;           // Comparator result.
  logic [31:0] rd;              // Last read data.
  logic        er;              // Last error response.
  int          n_errors = 0;    // Mismatches seen.
  int          total_checks = 0; // Comparisons made.

  // The bus clock toggles every 5 ns.
  always #5 pclk = ~pclk;

  dbgca_core_model core (.pclk(pclk), .next_addr(req), .core_addr(core_addr));

  dbgca_top uut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_module_enable(mod_en), .trig_begin_align(align),
    .end_trace_reset(etr), .core_addr(core_addr), .cmp_a_match(match));

  // Compares a value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; the answer is taken at the edge that sees pready.
  // Only the watchdog ends a wait that never sees the answer.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads both bytes and compares them with the expected pair.
  task automatic rd2(input logic [7:0] u, input logic [7:0] l);
    apb(1'b0, A_UP, 32'h0);
    chk("upper byte", rd, {24'h0, u});
    apb(1'b0, A_LO, 32'h0);
    chk("lower byte", rd, {24'h0, l});
  endtask

  // Lets the core issue an address and checks the match a few edges later.
  // The address changes on a rising edge; the match is read on a falling
  // edge, where it has settled.
  task automatic mt(input dbgca_addr_t a, input logic e);
    @(posedge pclk);
    req <= a;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("match", {31'h0, match}, {31'h0, e});
  endtask

  // Arms the end-trace request, then pulses the chosen reset.
  task automatic rst(input logic p, input logic e, input logic al);
    @(posedge pclk);
    mod_en <= e;
    align <= al;
    etr <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    por_n <= p;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    etr <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short long after the tests should have ended.
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    finish_test;
  end

  // Main sequence of tests.
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rd2(8'hff, 8'hfe);
    mt(16'hfffe, 1'b1);
    // The status word shows the standing match, with keep and enable low.
    apb(1'b0, A_ST, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b1, A_UP, 32'h12);
    apb(1'b1, A_LO, 32'h34);
    rd2(8'h12, 8'h34);
    mt(16'h1234, 1'b1);
    // A single wrong bit in either byte, either polarity, must break it.
    for (int i = 0; i < 16; i++)
      mt(16'h1234 ^ (16'h1 << i), 1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Only enable high with end alignment spares the bytes.
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, A_UP, 32'h5a);
      apb(1'b1, A_LO, 32'ha5);
      rst(1'b1, k[0], k[1]);
      rd2((k == 1) ? 8'h5a : 8'hff, (k == 1) ? 8'ha5 : 8'hfe);
    end
    apb(1'b1, A_UP, 32'h5a);
    rst(1'b0, 1'b1, 1'b0);
    rd2(8'hff, 8'hfe);
    mt(16'hfffe, 1'b1);
    finish_test;
  end
endmodule

`default_nettype wire
